// ==== design/ohe_pkg.sv ====
// Shared constants and types of the overlay region header engine
package ohe_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] OHE_CTRL_OFS = 8'h00;
  localparam logic [7:0] OHE_FIRST_OFS = 8'h04;
  localparam logic [7:0] OHE_STATUS_OFS = 8'h08;
  localparam logic [7:0] OHE_CUR_OFS = 8'h0C;
  localparam logic [31:0] OHE_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] OHE_CTRL_MASK = 32'h0000_FF07;
  localparam logic [31:0] OHE_FIRST_RST = 32'h0000_0000;
  localparam int OHE_EN_BIT = 0;
  localparam int OHE_PROG_BIT = 1;
  localparam int OHE_AADIS_BIT = 2;
  localparam int OHE_AAVAL_LSB = 8;
  localparam int OHE_UNDER_BIT = 2;
  localparam logic [1:0] OHE_OKAY = 2'h0;
  localparam logic [1:0] OHE_SLVERR = 2'h2;
  // ----------------------------------------
  // Header words and field positions
  // ----------------------------------------
  localparam int OHE_HW_CTRL = 0;
  localparam int OHE_HW_LINE = 1;
  localparam int OHE_HW_TOTAL = 2;
  localparam int OHE_HW_POSB = 3;
  localparam int OHE_HW_POST = 4;
  localparam int OHE_HW_BOT = 5;
  localparam int OHE_HW_TOP = 6;
  localparam int OHE_HW_PAL = 7;
  localparam int OHE_HW_NEXT = 8;
  localparam logic [3:0] OHE_HDR_LAST = 4'h8;
  localparam int OHE_SLL_BIT = 0;
  localparam int OHE_NP_BIT = 1;
  localparam int OHE_FM_LSB = 2;
  localparam int OHE_MIXING_MODE_SELECT_LSB = 4;
  localparam int OHE_PPL_LSB = 16;
  localparam int OHE_TSA_LSB = 0;
  localparam int OHE_CC_LSB = 8;
  localparam int OHE_PITCH_LSB = 16;
  localparam int OHE_TPC_LSB = 0;
  localparam int OHE_X_LSB = 0;
  localparam int OHE_Y_LSB = 12;
  localparam int OHE_MIW_LSB = 24;
  localparam int OHE_MIX_GAIN_LSB = 23;
  localparam logic [1:0] OHE_FM_RSVD = 2'h3;
  localparam logic [1:0] OHE_FM_NONE = 2'h0;
  // ----------------------------------------
  // Engine states
  // ----------------------------------------
  typedef enum logic [2:0] {
    S_IDLE, S_HDR, S_PAL, S_WAIT, S_LFETCH, S_LINE, S_STOP
  } ohe_st_t;
endpackage

// ==== design/ohe_clut_if.sv ====
// Colour table write and read bundle
`timescale 1ns/1ps
`default_nettype none
interface ohe_clut_if;
  logic we;
  logic [7:0] waddr;
  logic [31:0] wdata;
  logic [7:0] raddr;
  logic [31:0] rdata;
  modport engine(output we, waddr, wdata, raddr, input rdata);
  modport store(input we, waddr, wdata, raddr, output rdata);
endinterface
`default_nettype wire

// ==== design/ohe_clut.sv ====
// Colour look-up table, 256 words of flip-flops
`timescale 1ns/1ps
`default_nettype none
module ohe_clut (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Table access
  ohe_clut_if.store bus
);
  typedef struct packed {
    logic [255:0][31:0] ent;
  } ohe_clut_t;

  ohe_clut_t r, n;

  always_comb begin
    n = r;
    if (bus.we) begin
      n.ent[bus.waddr] = bus.wdata;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign bus.rdata = r.ent[bus.raddr];

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Colour written is readable next cycle
  a_clut_store: assert property (bus.we |=> r.ent[$past(bus.waddr)] == $past(bus.wdata))
    else $error("colour table entry not stored");
endmodule
`default_nettype wire

// ==== design/ohe_engine.sv ====
// Overlay region header engine: list walker, palette loader, pixel stream
//
// Implementation choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// Function
// - Palette pointer addresses first colour actually loaded
// - New-palette flag triggers palette fetch
// - Field fetch starts at top/bottom pointer
// - Identical top and bottom pointers allowed
// - Next region fetched from next pointer
// - Stop-list flag ends list walking
// - Region ends at vertical end line
// - Region starts at horizontal start position
// - Region ends at horizontal end position
// - Progressive shows twice end-minus-start lines
// - Interlaced: end-minus-start lines per field
// - Total pixel count caps each block's pixels per field
// - Pitch added to block address per line
// - Per-line pixel count caps every line
// - Colours written from table start address
// - Colour count colours loaded into table
// - Four mixing modes with weight and gain
// - Only one filter mode at once
// - Antialias only on first and last lines
// - Palette complete before region display
// - Mixing encoding per-pixel/global/proportional/full
// - No new palette keeps previous table
module ohe_engine (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Display timing
  input wire logic fld_start,
  input wire logic line_start,
  input wire logic [10:0] line_num,
  input wire logic field_bottom,
  input wire logic pix_en,
  input wire logic [11:0] pix_pos,
  // SDRAM read port
  output logic mem_req,
  output logic [31:0] mem_addr,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  // Pixel stream to compositor
  output logic px_valid,
  output logic [31:0] px_rgba,
  output logic [1:0] px_mix_mode,
  output logic [7:0] px_mix_weight,
  output logic [8:0] px_mix_gain,
  output logic [1:0] px_filter_mode,
  output logic px_aa_apply,
  output logic [7:0] px_aa_value
);
  typedef struct packed {
    logic aw_got;
    logic [7:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [31:0] ctrl;
    logic [31:0] first;
    logic underrun;
    ohe_pkg::ohe_st_t st;
    logic [31:0] spec;
    logic [3:0] hidx;
    logic [8:0][31:0] hdr;
    logic [8:0] pal_cnt;
    logic [31:0] top_a;
    logic [31:0] bot_a;
    logic [31:0] line_a;
    logic use_bot;
    logic pend;
    logic [31:0] word;
    logic wvalid;
    logic [31:0] nword;
    logic nvalid;
    logic [1:0] bsel;
    logic [11:0] line_px;
    logic [21:0] tot_px;
    logic [21:0] tot_bot_px;
    logic aa_line;
    logic pix_valid;
    logic [31:0] pix_rgba;
  } ohe_state_t;

  ohe_state_t r, n;
  ohe_clut_if clut_bus ();

  ohe_clut u_clut (
    .aclk(aclk),
    .aresetn(aresetn),
    .bus(clut_bus)
  );

  // ----------------------------------------
  // Header fields
  // ----------------------------------------
  logic stop_list_flag, np;
  logic [1:0] fm, mixing_mode_select;
  logic [11:0] ppl, x_left, x_right;
  logic [7:0] tsa, cc, mix_weight;
  logic [12:0] pitch;
  logic [21:0] tpc;
  logic [10:0] y_top, y_bot;
  logic [8:0] mix_gain;
  logic [31:0] pal_ptr, nxt_ptr;
  assign stop_list_flag = r.hdr[ohe_pkg::OHE_HW_CTRL][ohe_pkg::OHE_SLL_BIT];
  assign np = r.hdr[ohe_pkg::OHE_HW_CTRL][ohe_pkg::OHE_NP_BIT];
  assign fm = r.hdr[ohe_pkg::OHE_HW_CTRL][ohe_pkg::OHE_FM_LSB +: 2];
  assign mixing_mode_select = r.hdr[ohe_pkg::OHE_HW_CTRL][ohe_pkg::OHE_MIXING_MODE_SELECT_LSB +: 2];
  assign ppl = r.hdr[ohe_pkg::OHE_HW_CTRL][ohe_pkg::OHE_PPL_LSB +: 12];
  assign tsa = r.hdr[ohe_pkg::OHE_HW_LINE][ohe_pkg::OHE_TSA_LSB +: 8];
  assign cc = r.hdr[ohe_pkg::OHE_HW_LINE][ohe_pkg::OHE_CC_LSB +: 8];
  assign pitch = r.hdr[ohe_pkg::OHE_HW_LINE][ohe_pkg::OHE_PITCH_LSB +: 13];
  assign tpc = r.hdr[ohe_pkg::OHE_HW_TOTAL][ohe_pkg::OHE_TPC_LSB +: 22];
  assign x_left = r.hdr[ohe_pkg::OHE_HW_POSB][ohe_pkg::OHE_X_LSB +: 12];
  assign y_bot = r.hdr[ohe_pkg::OHE_HW_POSB][ohe_pkg::OHE_Y_LSB +: 11];
  assign mix_weight = r.hdr[ohe_pkg::OHE_HW_POSB][ohe_pkg::OHE_MIW_LSB +: 8];
  assign x_right = r.hdr[ohe_pkg::OHE_HW_POST][ohe_pkg::OHE_X_LSB +: 12];
  assign y_top = r.hdr[ohe_pkg::OHE_HW_POST][ohe_pkg::OHE_Y_LSB +: 11];
  assign mix_gain = r.hdr[ohe_pkg::OHE_HW_POST][ohe_pkg::OHE_MIX_GAIN_LSB +: 9];
  assign pal_ptr = r.hdr[ohe_pkg::OHE_HW_PAL];
  assign nxt_ptr = r.hdr[ohe_pkg::OHE_HW_NEXT];

  // ----------------------------------------
  // Line and pixel position
  // ----------------------------------------
  logic prog, en, fl_bot;
  logic [10:0] fl;
  logic in_reg, done_reg, line_evt, x_in, mem_ok;
  logic [21:0] shown_px;
  assign en = r.ctrl[ohe_pkg::OHE_EN_BIT];
  assign prog = r.ctrl[ohe_pkg::OHE_PROG_BIT];
  // Progressive: two frame lines per field line, odd ones from bottom block
  assign fl = prog ? {1'b0, line_num[10:1]} : line_num;
  assign fl_bot = prog ? line_num[0] : field_bottom;
  assign in_reg = (fl >= y_top) && (fl < y_bot);
  assign done_reg = fl >= y_bot;
  assign line_evt = line_start || r.pend;
  // Each block keeps its own total: progressive shows both in one pass
  assign shown_px = r.use_bot ? r.tot_bot_px : r.tot_px;
  assign x_in = (pix_pos >= x_left) && (pix_pos < x_right)
    && (r.line_px < ppl) && (shown_px < tpc);
  assign mem_ok = mem_req && mem_ack;

  // ----------------------------------------
  // Bus handshakes and fetch port
  // ----------------------------------------
  assign s_axi_awready = !r.aw_got && !r.bvalid;
  assign s_axi_wready = !r.w_got && !r.bvalid;
  assign s_axi_arready = !r.rvalid;
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_bresp = r.bresp;
  assign s_axi_rvalid = r.rvalid;
  assign s_axi_rdata = r.rdata;
  assign s_axi_rresp = r.rresp;

  // Only one word of lookahead: slow SDRAM shows up as underrun
  always_comb begin
    mem_req = 1'b0;
    mem_addr = r.line_a;
    unique case (r.st)
      ohe_pkg::S_HDR: begin
        mem_req = 1'b1;
        mem_addr = r.spec + {26'h0, r.hidx, 2'h0};
      end
      ohe_pkg::S_PAL: begin
        mem_req = 1'b1;
        mem_addr = pal_ptr + {21'h0, r.pal_cnt, 2'h0};
      end
      ohe_pkg::S_LFETCH: mem_req = 1'b1;
      ohe_pkg::S_LINE: mem_req = !(r.wvalid && r.nvalid);
      ohe_pkg::S_IDLE, ohe_pkg::S_WAIT, ohe_pkg::S_STOP: mem_req = 1'b0;
    endcase
  end

  assign clut_bus.we = (r.st == ohe_pkg::S_PAL) && mem_ok;
  assign clut_bus.waddr = tsa + r.pal_cnt[7:0];
  assign clut_bus.wdata = mem_rdata;
  assign clut_bus.raddr = r.word[{r.bsel, 3'h0} +: 8];

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    logic [31:0] wmask;
    wmask = '0;
    n = r;
    n.pix_valid = 1'b0;
    for (int b = 0; b < 4; b++) begin
      wmask[b*8 +: 8] = {8{r.w_strb[b]}};
    end
    if (s_axi_awvalid && s_axi_awready) begin
      n.aw_got = 1'b1;
      n.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      n.w_got = 1'b1;
      n.w_data = s_axi_wdata;
      n.w_strb = s_axi_wstrb;
    end
    if (r.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end
    if (r.aw_got && r.w_got) begin
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = ohe_pkg::OHE_OKAY;
      unique case (r.aw_addr)
        ohe_pkg::OHE_CTRL_OFS:
          n.ctrl = ((r.ctrl & ~wmask) | (r.w_data & wmask)) & ohe_pkg::OHE_CTRL_MASK;
        ohe_pkg::OHE_FIRST_OFS: n.first = (r.first & ~wmask) | (r.w_data & wmask);
        ohe_pkg::OHE_STATUS_OFS: begin
          if ((r.w_data & wmask) != 32'h0 && r.w_data[ohe_pkg::OHE_UNDER_BIT]) begin
            n.underrun = 1'b0;
          end
        end
        ohe_pkg::OHE_CUR_OFS: n.bresp = ohe_pkg::OHE_OKAY;
        default: n.bresp = ohe_pkg::OHE_SLVERR;
      endcase
    end
    if (r.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      n.rvalid = 1'b1;
      n.rresp = ohe_pkg::OHE_OKAY;
      unique case (s_axi_araddr)
        ohe_pkg::OHE_CTRL_OFS: n.rdata = r.ctrl;
        ohe_pkg::OHE_FIRST_OFS: n.rdata = r.first;
        ohe_pkg::OHE_STATUS_OFS:
          n.rdata = {29'h0, r.underrun, r.st == ohe_pkg::S_STOP,
                     r.st != ohe_pkg::S_IDLE && r.st != ohe_pkg::S_STOP};
        ohe_pkg::OHE_CUR_OFS: n.rdata = r.spec;
        default: begin
          n.rdata = 32'h0;
          n.rresp = ohe_pkg::OHE_SLVERR;
        end
      endcase
    end

    // Engine; underrun set below a clear above so the set wins
    unique case (r.st)
      ohe_pkg::S_IDLE, ohe_pkg::S_STOP: n.pend = 1'b0;
      ohe_pkg::S_HDR: begin
        if (mem_ok) begin
          n.hdr[r.hidx] = mem_rdata;
          n.hidx = r.hidx + 4'h1;
          if (r.hidx == ohe_pkg::OHE_HDR_LAST) begin
            n.tot_px = '0;
            n.tot_bot_px = '0;
            n.top_a = r.hdr[ohe_pkg::OHE_HW_TOP];
            n.bot_a = r.hdr[ohe_pkg::OHE_HW_BOT];
            n.pal_cnt = '0;
            // Table left as is without a new palette
            if (np && cc != 8'h0) begin
              n.st = ohe_pkg::S_PAL;
            end else begin
              n.st = ohe_pkg::S_WAIT;
            end
          end
        end
      end
      ohe_pkg::S_PAL: begin
        if (mem_ok) begin
          n.pal_cnt = r.pal_cnt + 9'h1;
          // Display waits until the last colour is in
          if (r.pal_cnt + 9'h1 == {1'b0, cc}) begin
            n.st = ohe_pkg::S_WAIT;
          end
        end
      end
      ohe_pkg::S_WAIT: begin
        if (line_evt) begin
          n.pend = 1'b0;
          if (done_reg) begin
            if (stop_list_flag) begin
              n.st = ohe_pkg::S_STOP;
            end else begin
              n.spec = nxt_ptr;
              n.hidx = '0;
              n.st = ohe_pkg::S_HDR;
            end
          end else if (in_reg) begin
            n.use_bot = fl_bot;
            n.line_a = fl_bot ? r.bot_a : r.top_a;
            n.aa_line = !r.ctrl[ohe_pkg::OHE_AADIS_BIT]
              && (fl == y_top || fl == y_bot - 11'h1);
            n.st = ohe_pkg::S_LFETCH;
          end
        end
      end
      ohe_pkg::S_LFETCH: begin
        if (mem_ok) begin
          n.word = mem_rdata;
          n.wvalid = 1'b1;
          n.nvalid = 1'b0;
          n.bsel = '0;
          n.line_px = '0;
          n.line_a = r.line_a + 32'h4;
          n.st = ohe_pkg::S_LINE;
        end
      end
      ohe_pkg::S_LINE: begin
        if (line_start) begin
          if (r.use_bot) begin
            n.bot_a = r.bot_a + {19'h0, pitch};
          end else begin
            n.top_a = r.top_a + {19'h0, pitch};
          end
          n.pend = 1'b1;
          n.st = ohe_pkg::S_WAIT;
        end else begin
          if (pix_en && x_in) begin
            n.line_px = r.line_px + 12'h1;
            if (r.use_bot) begin
              n.tot_bot_px = r.tot_bot_px + 22'h1;
            end else begin
              n.tot_px = r.tot_px + 22'h1;
            end
            if (r.wvalid) begin
              n.pix_valid = 1'b1;
              n.pix_rgba = clut_bus.rdata;
              n.bsel = r.bsel + 2'h1;
              if (r.bsel == 2'h3) begin
                n.word = r.nword;
                n.wvalid = r.nvalid;
                n.nvalid = 1'b0;
              end
            end else begin
              n.underrun = 1'b1;
            end
          end
          if (mem_ok) begin
            n.line_a = r.line_a + 32'h4;
            if (!n.wvalid) begin
              n.word = mem_rdata;
              n.wvalid = 1'b1;
            end else begin
              n.nword = mem_rdata;
              n.nvalid = 1'b1;
            end
          end
        end
      end
    endcase

    // Each field walks the list again from the first region
    if (fld_start) begin
      n.pend = 1'b0;
      n.wvalid = 1'b0;
      n.nvalid = 1'b0;
      n.hidx = '0;
      n.spec = r.first;
      n.st = en ? ohe_pkg::S_HDR : ohe_pkg::S_IDLE;
    end else if (!en) begin
      n.st = ohe_pkg::S_IDLE;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
      r.ctrl <= ohe_pkg::OHE_CTRL_RST;
      r.first <= ohe_pkg::OHE_FIRST_RST;
      r.st <= ohe_pkg::S_IDLE;
    end else begin
      r <= n;
    end
  end

  // ----------------------------------------
  // Pixel outputs
  // ----------------------------------------
  assign px_valid = r.pix_valid;
  assign px_rgba = r.pix_rgba;
  assign px_mix_mode = mixing_mode_select;
  assign px_mix_weight = mix_weight;
  assign px_mix_gain = mix_gain;
  // Reserved code would mean both filters, so it falls back to none
  assign px_filter_mode = (fm == ohe_pkg::OHE_FM_RSVD) ? ohe_pkg::OHE_FM_NONE : fm;
  assign px_aa_apply = r.aa_line && (r.st == ohe_pkg::S_LINE);
  assign px_aa_value = r.ctrl[ohe_pkg::OHE_AAVAL_LSB +: 8];

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_hdr_last;
    r.st == ohe_pkg::S_HDR && mem_ok && r.hidx == ohe_pkg::OHE_HDR_LAST && !fld_start && en;
  endsequence
  sequence s_region_over;
    r.st == ohe_pkg::S_WAIT && line_evt && done_reg && !fld_start && en;
  endsequence

  a_pal_load: assert property (s_hdr_last |=> (r.st == ohe_pkg::S_PAL) == ($past(np) && $past(cc) != 8'h0))
    else $error("palette fetch decision wrong");
  a_pal_first: assert property (r.st == ohe_pkg::S_PAL && r.pal_cnt == 9'h0 |-> mem_addr == pal_ptr)
    else $error("palette fetch not at palette pointer");
  a_pal_count: assert property (r.st == ohe_pkg::S_PAL |-> r.pal_cnt < {1'b0, cc})
    else $error("too many colours loaded");
  a_pal_before_px: assert property (r.st == ohe_pkg::S_LFETCH && np && cc != 8'h0 |-> r.pal_cnt == {1'b0, cc})
    else $error("pixel shown during palette load");
  a_next_spec: assert property (s_region_over ##0 !stop_list_flag |=> r.st == ohe_pkg::S_HDR && r.spec == $past(nxt_ptr))
    else $error("next region not fetched from next pointer");
  a_list_stop: assert property (s_region_over ##0 stop_list_flag |=> r.st == ohe_pkg::S_STOP)
    else $error("list not stopped");
  a_line_base: assert property (r.st == ohe_pkg::S_WAIT && line_evt && in_reg && !fld_start && en
    |=> r.st == ohe_pkg::S_LFETCH && mem_addr == (r.use_bot ? r.bot_a : r.top_a))
    else $error("line fetch not at block address");
  a_pitch_step: assert property (r.st == ohe_pkg::S_LINE && line_start && r.use_bot && !fld_start
    |=> r.bot_a == $past(r.bot_a) + {19'h0, $past(pitch)})
    else $error("pitch not added to bottom address");
  a_line_cap: assert property (px_valid |-> r.line_px <= ppl && r.tot_px <= tpc && r.tot_bot_px <= tpc)
    else $error("pixel count exceeded");
  a_horiz_span: assert property (px_valid |-> $past(pix_pos) >= x_left && $past(pix_pos) < x_right)
    else $error("pixel outside horizontal span");
  a_bresp_hold: assert property (r.bvalid && !s_axi_bready |=> r.bvalid && $stable(r.bresp))
    else $error("write response dropped");
endmodule
`default_nettype wire

// ==== test/ohe_sdram_model.sv ====
// Behavioural SDRAM behind the engine read port
`timescale 1ns/1ps
`default_nettype none
module ohe_sdram_model (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Answer delay in cycles
  input wire logic [1:0] lat,
  // Read port
  input wire logic mem_req,
  input wire logic [31:0] mem_addr,
  output logic mem_ack,
  output logic [31:0] mem_rdata,
  // Words handed out so far
  output logic [15:0] ack_count
);
  logic [31:0] mem [0:255];
  logic [1:0] wait_r;
  logic [31:0] last_r;
  assign mem_ack = mem_req && (wait_r == lat);
  // Inverted stale word between answers, so no stale data passes by luck
  assign mem_rdata = mem_ack ? mem[mem_addr[9:2]] : ~last_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wait_r <= 2'h0;
      last_r <= 32'h0;
      ack_count <= 16'h0;
    end else begin
      wait_r <= (mem_req && !mem_ack) ? wait_r + 2'h1 : 2'h0;
      if (mem_ack) begin
        last_r <= mem_rdata;
        ack_count <= ack_count + 16'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== test/tb.sv ====
// Self-checking bench for the overlay region header engine
`timescale 1ns/1ps
`default_nettype none
module tb;
  typedef struct packed {logic wr; logic [7:0] a; logic [31:0] d; logic [31:0] rd; logic [1:0] resp;} ohe_row_t;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0;
  logic s_axi_bready = 1'h1, s_axi_rready = 1'h1;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic fld_start = 1'h0, line_start = 1'h0, field_bottom = 1'h0, pix_en = 1'h0;
  logic [10:0] line_num = 11'h0;
  logic [11:0] pix_pos = 12'h0;
  logic [1:0] lat = 2'h0;
  logic mem_req, mem_ack, px_valid, px_aa_apply;
  logic [31:0] mem_addr, mem_rdata, px_rgba;
  logic [1:0] px_mix_mode, px_filter_mode;
  logic [7:0] px_mix_weight, px_aa_value;
  logic [8:0] px_mix_gain;
  logic [15:0] ack_count;
  logic [61:0] got[$];
  int err_count = 0, compares = 0;
  // ------
  // Stimulus data
  // ------
  logic [31:0] hdr1[9] = '{32'h0004_0016, 32'h0010_0302, 32'h0000_000A, 32'h4000_600A, 32'h2A80_3014,
    32'h0000_0200, 32'h0000_0200, 32'h0000_0104, 32'h0000_0040};
  logic [31:0] hdr2[9] = '{32'h0008_0039, 32'h0010_0000, 32'h0000_0064, 32'h8000_800A, 32'hFF80_700C,
    32'h0000_0300, 32'h0000_0300, 32'h0000_0180, 32'h0000_0000};
  logic [31:0] col[3] = '{32'h1122_3380, 32'h4455_6640, 32'h7788_9900};
  int pix_col[12] = '{0, 1, 2, 0, 2, 2, 1, 0, 1, 1, 1, 2};
  logic [11:0] pix_aa = 12'hF0F;
  // Progressive shows each field line twice, top block then bottom
  int pmap[24] = '{0, 1, 2, 3, 0, 1, 2, 3, 4, 5, 6, 7, 4, 5, 6, 7, 8, 9, 8, 9, 10, 11, 10, 11};
  ohe_row_t rows[5] = '{
    '{1'h0, ohe_pkg::OHE_CTRL_OFS, 32'h0, ohe_pkg::OHE_CTRL_RST, ohe_pkg::OHE_OKAY},
    '{1'h0, ohe_pkg::OHE_FIRST_OFS, 32'h0, ohe_pkg::OHE_FIRST_RST, ohe_pkg::OHE_OKAY},
    '{1'h1, ohe_pkg::OHE_CTRL_OFS, 32'hFFFF_FFFE, 32'h0000_FF06, ohe_pkg::OHE_OKAY},
    '{1'h1, ohe_pkg::OHE_FIRST_OFS, 32'h1234_5678, 32'h1234_5678, ohe_pkg::OHE_OKAY},
    '{1'h1, 8'h10, 32'hFFFF_FFFF, 32'h0, ohe_pkg::OHE_SLVERR}};

  ohe_engine i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .fld_start,
    .line_start, .line_num, .field_bottom, .pix_en, .pix_pos, .mem_req, .mem_addr, .mem_ack, .mem_rdata,
    .px_valid, .px_rgba, .px_mix_mode, .px_mix_weight, .px_mix_gain, .px_filter_mode, .px_aa_apply,
    .px_aa_value);
  ohe_sdram_model i_mem (.aclk, .aresetn, .lat, .mem_req, .mem_addr, .mem_ack, .mem_rdata, .ack_count);

  always #50 aclk = ~aclk;
  always @(posedge aclk) begin
    if (px_valid === 1'h1) begin
      got.push_back({px_aa_apply, px_aa_value, px_mix_mode, px_filter_mode, px_mix_weight, px_mix_gain, px_rgba});
    end
  end

  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic complete_run();
    if (err_count == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Handshakes judged mid-cycle, released at the edge that completes them
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_ok, w_ok, b_ok;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    b_ok = 1'h0;
    while (!b_ok) begin
      @(negedge aclk);
      aw_ok = s_axi_awvalid & s_axi_awready;
      w_ok = s_axi_wvalid & s_axi_wready;
      b_ok = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
      if (aw_ok) s_axi_awvalid <= 1'h0;
      if (w_ok) s_axi_wvalid <= 1'h0;
    end
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_ok, r_ok;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    r_ok = 1'h0;
    while (!r_ok) begin
      @(negedge aclk);
      ar_ok = s_axi_arvalid & s_axi_arready;
      r_ok = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ar_ok) s_axi_arvalid <= 1'h0;
    end
  endtask

  // Pixel positions 8..19 straddle the left edge of both regions and the right edge of the second
  task automatic do_line(input int n);
    line_num <= 11'(n);
    line_start <= 1'h1;
    @(posedge aclk);
    line_start <= 1'h0;
    repeat (10) @(posedge aclk);
    for (int p = 8; p < 20; p++) begin
      pix_en <= 1'h1;
      pix_pos <= 12'(p);
      @(posedge aclk);
      pix_en <= 1'h0;
      @(posedge aclk);
    end
    repeat (6) @(posedge aclk);
  endtask

  task automatic run_field(input logic fb, input logic [1:0] lt, input logic aa_on, input logic pg);
    logic [15:0] acks;
    logic [61:0] e;
    int k;
    field_bottom <= fb;
    lat <= lt;
    fld_start <= 1'h1;
    @(posedge aclk);
    fld_start <= 1'h0;
    repeat (60) @(posedge aclk);
    got.delete();
    for (int n = 2 << pg; n < 8 << pg; n++) do_line(n);
    @(negedge aclk);
    acks = ack_count;
    @(posedge aclk);
    do_line(8 << pg);
    do_line((8 << pg) + 1);
    @(negedge aclk);
    check("acks after stop", ack_count, acks);
    check("pixel count", got.size(), pg ? 24 : 12);
    foreach (got[i]) begin
      k = pg ? pmap[i] : i;
      e = {aa_on & pix_aa[k], 8'h5A, k < 10 ? 4'h5 : 4'hE, k < 10 ? 17'h08055 : 17'h101FF, col[pix_col[k]]};
      check("pixel", got[i], e);
    end
    @(posedge aclk);
  endtask

  // ------
  // Sequence
  // ------
  initial begin
    logic [1:0] r;
    logic [31:0] d;
    foreach (hdr1[k]) begin
      i_mem.mem[k] = hdr1[k];
      i_mem.mem[16 + k] = hdr2[k];
    end
    i_mem.mem[64] = 32'hDEAD_0000;
    for (int k = 0; k < 3; k++) i_mem.mem[65 + k] = col[k];
    i_mem.mem[128] = 32'h0204_0302;
    i_mem.mem[132] = 32'h0203_0404;
    i_mem.mem[136] = 32'h0000_0303;
    i_mem.mem[192] = 32'h0202_0403;
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    @(negedge aclk);
    check("idle after reset", {mem_req, px_valid, s_axi_bvalid, s_axi_rvalid}, 64'h0);
    @(posedge aclk);
    foreach (rows[i]) begin
      if (rows[i].wr) begin
        axi_wr(rows[i].a, rows[i].d, r);
        check("bresp", r, rows[i].resp);
      end
      axi_rd(rows[i].a, d, r);
      check("rdata", d, rows[i].rd);
      check("rresp", r, rows[i].resp);
    end
    axi_wr(ohe_pkg::OHE_FIRST_OFS, 32'h0, r);
    axi_wr(ohe_pkg::OHE_CTRL_OFS, 32'h0000_5A01, r);
    run_field(1'h0, 2'h0, 1'h1, 1'h0);
    run_field(1'h1, 2'h2, 1'h1, 1'h0);
    axi_wr(ohe_pkg::OHE_CTRL_OFS, 32'h0000_5A05, r);
    run_field(1'h0, 2'h1, 1'h0, 1'h0);
    axi_wr(ohe_pkg::OHE_CTRL_OFS, 32'h0000_5A03, r);
    run_field(1'h0, 2'h0, 1'h1, 1'h1);
    axi_rd(ohe_pkg::OHE_STATUS_OFS, d, r);
    check("status", d, 32'h2);
    axi_rd(ohe_pkg::OHE_CUR_OFS, d, r);
    check("cur spec", d, 32'h40);
    complete_run();
  end

  initial begin
    repeat (6000) @(posedge aclk);
    err_count++;
    complete_run();
  end
endmodule
`default_nettype wire
